/* File: hw/cglb_bank_manager.sv */
// control gain bank manager: bank select, 24-byte gain blocks, bank activate, error scaling
// assumes a command layer that hands over one command start and then data bytes
`timescale 1ns/1ps
module cglb_bank_manager #(
  parameter int NUM_RAILS = cglb_pkg::MAX_RAILS,
  parameter int ERR_W = cglb_pkg::ERR_WIDTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [cglb_pkg::PAGE_W-1:0] pageSel,
  input wire logic cmdStart,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic wrValid,
  input wire logic [7:0] wrData,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic rdLast,
  output logic nackInvalid,
  input wire logic errValid,
  input wire logic [cglb_pkg::PAGE_W-1:0] errRail,
  input wire logic signed [ERR_W-1:0] errSample,
  output logic scaledValid,
  output logic signed [ERR_W+cglb_pkg::MULT_W:0] scaledErr,
  output logic [2:0] errSegment,
  output logic [1:0] frontEndGain,
  output logic [3:0] resolutionMv,
  output logic [NUM_RAILS-1:0] activeBankSel
);
  import cglb_pkg::*;

  localparam int RAM_WORDS = NUM_RAILS * RAM_BANKS * BLOCK_WORDS;
  localparam int HW_WORDS = NUM_RAILS * HW_BANKS * BLOCK_WORDS;

  // storage index helpers, shared by write, read, copy and scaling
  function automatic int ramIdx(input int rail, input int bank, input int w);
    return (rail * RAM_BANKS + bank) * BLOCK_WORDS + w;
  endfunction

  function automatic int hwIdx(input int rail, input logic sel, input int w);
    return (rail * HW_BANKS + int'(sel)) * BLOCK_WORDS + w;
  endfunction

  function automatic int byteWord(input logic [CNT_W-1:0] k);
    return int'(k) / BYTE_LANES;
  endfunction

  // bit position of block byte k inside its word; high byte first,
  // except the third coefficient word which carries its low half first
  function automatic int byteLsb(input logic [CNT_W-1:0] k);
    int pos;
    pos = (BYTE_LANES - 1 - (int'(k) % BYTE_LANES)) * BYTE_W;
    if (byteWord(k) == COEF_THREE_IDX) begin
      pos = pos ^ HALF_W;
    end
    return pos;
  endfunction

  function automatic logic isRamBank(input logic [7:0] b);
    return b <= BANK_LIGHT;
  endfunction

  cglb_state_type state;
  logic [7:0] bankSel;
  logic [PAGE_W-1:0] curPage;
  logic [CNT_W-1:0] byteCnt;
  logic tgtRam;
  logic [1:0] tgtBank;
  logic [31:0] asmWord [BLOCK_WORDS];
  logic [31:0] rdWord [BLOCK_WORDS];
  logic [31:0] ramWord [RAM_WORDS];
  logic [31:0] hwWord [HW_WORDS];
  logic [NUM_RAILS-1:0] activeSel;
  logic blockDone;
  logic actRam;
  logic actSwap;
  logic [31:0] scGain;
  logic [31:0] scLimit;
  logic signed [ERR_W+MULT_W:0] scProduct;
  logic [2:0] scSegment;

  assign blockDone = (state == ST_GET_BLOCK) && wrValid && (byteCnt == LAST_BYTE);
  assign actRam = (state == ST_GET_ACT) && wrValid && isRamBank(wrData);
  assign actSwap = (state == ST_GET_ACT) && wrValid && (wrData == BANK_INACTIVE);

  // command sequencer; a new command start is ignored until back in idle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmdStart && !cmdRead) begin
            case (cmdCode)
              CMD_BANK_SELECT: state <= ST_GET_BANK;
              CMD_BLOCK_XFER: state <= (isRamBank(bankSel) || bankSel == BANK_INACTIVE) ? ST_GET_BLOCK : ST_IDLE;
              CMD_BANK_ACTIVATE: state <= ST_GET_ACT;
              default: state <= ST_IDLE;
            endcase
          end else if (cmdStart && cmdCode == CMD_BLOCK_XFER && bankSel <= BANK_LIGHT) begin
            state <= ST_SEND_BLOCK;
          end else if (cmdStart && cmdCode == CMD_BLOCK_XFER && bankSel >= BANK_ACTIVE) begin
            state <= ST_SEND_BLOCK;
          end
        end
        ST_GET_BANK: state <= wrValid ? ST_IDLE : ST_GET_BANK;
        ST_GET_BLOCK: state <= blockDone ? ST_IDLE : ST_GET_BLOCK;
        ST_SEND_BLOCK: state <= (byteCnt == LAST_BYTE) ? ST_IDLE : ST_SEND_BLOCK;
        ST_GET_ACT: state <= wrValid ? ST_IDLE : ST_GET_ACT;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // global bank select; only the select command touches it
  // activate leaves select
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bankSel <= BANK_SELECT_RESET;
    end else if (state == ST_GET_BANK && wrValid) begin
      bankSel <= wrData;
    end
  end

  // page latched per command
  // target captured at start so a page change mid-block cannot split it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      curPage <= '0;
      tgtRam <= 1'b0;
      tgtBank <= 2'h0;
    end else if (state == ST_IDLE && cmdStart) begin
      curPage <= pageSel;
      tgtRam <= isRamBank(bankSel);
      tgtBank <= bankSel[1:0];
    end
  end

  // byte counter for block in and block out
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      byteCnt <= '0;
    end else if (state == ST_IDLE) begin
      byteCnt <= '0;
    end else if ((state == ST_GET_BLOCK && wrValid) || state == ST_SEND_BLOCK) begin
      byteCnt <= (byteCnt == LAST_BYTE) ? '0 : byteCnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int w = 0; w < BLOCK_WORDS; w++) begin
        asmWord[w] <= WORD_RESET;
      end
    end else if (state == ST_GET_BLOCK && wrValid) begin
      asmWord[byteWord(byteCnt)][byteLsb(byteCnt) +: BYTE_W] <= wrData;
    end
  end

  // read snapshot; taken at start so later writes cannot tear the reply
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int w = 0; w < BLOCK_WORDS; w++) begin
        rdWord[w] <= WORD_RESET;
      end
    end else if (state == ST_IDLE && cmdStart && cmdRead && cmdCode == CMD_BLOCK_XFER) begin
      for (int w = 0; w < BLOCK_WORDS; w++) begin
        if (isRamBank(bankSel)) begin
          rdWord[w] <= ramWord[ramIdx(int'(pageSel), int'(bankSel[1:0]), w)];
        end else if (bankSel == BANK_ACTIVE) begin
          rdWord[w] <= hwWord[hwIdx(int'(pageSel), activeSel[pageSel], w)];
        end else begin
          rdWord[w] <= hwWord[hwIdx(int'(pageSel), !activeSel[pageSel], w)];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ramWord[i] <= ((i % BLOCK_WORDS) == GAIN_WORD_IDX) ? GAIN_WORD_RESET : WORD_RESET;
      end
    end else if (blockDone && tgtRam) begin
      for (int w = 0; w < BLOCK_WORDS; w++) begin
        ramWord[ramIdx(int'(curPage), int'(tgtBank), w)] <= (w == BLOCK_WORDS - 1) ?
          {asmWord[w][WORD_W-1:BYTE_W], wrData} : asmWord[w];
      end
    end
  end

  // hardware banks: block commit to inactive bank, or copy from RAM
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < HW_WORDS; i++) begin
        hwWord[i] <= ((i % BLOCK_WORDS) == GAIN_WORD_IDX) ? GAIN_WORD_RESET : WORD_RESET;
      end
    end else if (blockDone && !tgtRam) begin
      for (int w = 0; w < BLOCK_WORDS; w++) begin
        hwWord[hwIdx(int'(curPage), !activeSel[curPage], w)] <= (w == BLOCK_WORDS - 1) ?
          {asmWord[w][WORD_W-1:BYTE_W], wrData} : asmWord[w];
      end
    end else if (actRam) begin
      for (int w = 0; w < BLOCK_WORDS; w++) begin
        hwWord[hwIdx(int'(curPage), !activeSel[curPage], w)] <= ramWord[ramIdx(int'(curPage), int'(wrData[1:0]), w)];
      end
    end
  end

  // swap without RAM
  // a RAM activate fills the inactive bank and flips on the same edge, so the loop never sees a half set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      activeSel <= '0;
    end else if (actRam || actSwap) begin
      activeSel[curPage] <= !activeSel[curPage];
    end
  end

  assign activeBankSel = activeSel;

  // read data path: one byte per cycle for blocks, one byte for bank select
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdValid <= 1'b0;
      rdData <= 8'h00;
      rdLast <= 1'b0;
    end else if (state == ST_SEND_BLOCK) begin
      rdValid <= 1'b1;
      rdData <= rdWord[byteWord(byteCnt)][byteLsb(byteCnt) +: BYTE_W];
      rdLast <= (byteCnt == LAST_BYTE);
    end else if (state == ST_IDLE && cmdStart && cmdRead && cmdCode == CMD_BANK_SELECT) begin
      rdValid <= 1'b1;
      rdData <= bankSel;
      rdLast <= 1'b1;
    end else begin
      rdValid <= 1'b0;
      rdData <= 8'h00;
      rdLast <= 1'b0;
    end
  end

  // invalid-data refusal, one-cycle pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nackInvalid <= 1'b0;
    end else if (state == ST_IDLE && cmdStart) begin
      case (cmdCode)
        CMD_BANK_SELECT: nackInvalid <= 1'b0;
        CMD_BLOCK_XFER: nackInvalid <= cmdRead ? (bankSel >= BANK_RSV_FIRST && bankSel <= BANK_RSV_LAST) :
          !(isRamBank(bankSel) || bankSel == BANK_INACTIVE);
        CMD_BANK_ACTIVATE: nackInvalid <= cmdRead;
        default: nackInvalid <= 1'b1;
      endcase
    end else if (state == ST_GET_ACT && wrValid) begin
      nackInvalid <= !(isRamBank(wrData) || wrData == BANK_INACTIVE);
    end else begin
      nackInvalid <= 1'b0;
    end
  end

  assign scGain = hwWord[hwIdx(int'(errRail), activeSel[errRail], GAIN_WORD_IDX)];
  assign scLimit = hwWord[hwIdx(int'(errRail), activeSel[errRail], LIMIT_WORD_IDX)];

  cglb_segment_scaler #(
    .ERR_W(ERR_W)
  ) u_scaler (
    .gainWord(scGain),
    .limitWord(scLimit),
    .errSample(errSample),
    .scaled(scProduct),
    .segment(scSegment)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scaledValid <= 1'b0;
      scaledErr <= '0;
      errSegment <= 3'h0;
    end else begin
      scaledValid <= errValid;
      if (errValid) begin
        scaledErr <= scProduct;
        errSegment <= scSegment;
      end
    end
  end

  // front gain and resolution
  // resolution halves with each gain step: 8, 4, 2, 1 mV
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frontEndGain <= 2'h0;
      resolutionMv <= RES_COARSE_MV;
    end else if (errValid) begin
      frontEndGain <= scGain[FE_GAIN_LSB +: 2];
      resolutionMv <= RES_COARSE_MV >> scGain[FE_GAIN_LSB +: 2];
    end
  end

  bank_select_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == ST_GET_BANK && wrValid) |=> (bankSel == $past(wrData) && state == ST_IDLE))
    else $error("bank select not stored");

  reserved_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == ST_IDLE && cmdStart && cmdRead && cmdCode == CMD_BLOCK_XFER &&
     bankSel >= BANK_RSV_FIRST && bankSel <= BANK_RSV_LAST) |=> (nackInvalid && !rdValid ##1 !rdValid))
    else $error("reserved bank read not refused");

  active_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == ST_IDLE && cmdStart && !cmdRead && cmdCode == CMD_BLOCK_XFER && bankSel == BANK_ACTIVE)
    |=> (nackInvalid && state == ST_IDLE))
    else $error("write to active bank not refused");

  block_length_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == ST_IDLE && cmdStart && cmdRead && cmdCode == CMD_BLOCK_XFER && bankSel == BANK_INACTIVE)
    |=> ##1 (rdValid && !rdLast) ##22 (rdValid && !rdLast) ##1 (rdValid && rdLast) ##1 !rdValid)
    else $error("block read is not 24 bytes");

  bank_swap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    actSwap |=> (activeSel[curPage] != $past(activeSel[curPage]) && !nackInvalid))
    else $error("swap did not flip active bank");

  select_kept_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == ST_GET_ACT && wrValid) |=> $stable(bankSel))
    else $error("activate changed bank select");

  scale_latency_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    errValid |=> (scaledValid && scaledErr == $past(scProduct)))
    else $error("scaled error late or wrong");

  resolution_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    scaledValid |-> (resolutionMv == (RES_COARSE_MV >> frontEndGain)))
    else $error("resolution does not match gain");
endmodule

/* File: hw/cglb_pkg.sv */
// constants for the control gain bank manager: commands, bank codes, field layout
// assumes a command layer that has already decoded the management link into bytes
// Behaviour
// - banks 00,01,02 are run, ramp, light sets
// - banks 03 to FD are reserved, refused
// - FE active hardware bank, FF inactive one
// - RAM bank blocks go to page slot
// - bank FF blocks use inactive hardware bank
// - bank FE reads active, write gets nack
// - 24 bytes high first except third word low half first, six words
// - gain word: front gain, five multipliers
// - limit word holds four 6-bit boundaries
// - activate of RAM bank loads hardware
// - activate FF swaps banks, no RAM
// - activate bank leaves global select alone
// - front gain 0..3 means 8,4,2,1 mV
// - five segments from four free limits
// - multipliers are 4.2 fixed, 4 is unity
// - two hardware banks, one select bit
// - up to four rails by page
package cglb_pkg;
  localparam int MAX_RAILS = 4;
  localparam int PAGE_W = 2;
  localparam int ERR_WIDTH = 9;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int BYTE_LANES = 4;
  localparam int BLOCK_WORDS = 6;
  localparam int BLOCK_BYTES = 24;
  localparam int RAM_BANKS = 3;
  localparam int HW_BANKS = 2;
  localparam int MULT_W = 6;
  localparam int LIMIT_W = 6;
  localparam int CNT_W = 5;
  // command codes on the management link
  localparam logic [7:0] CMD_BANK_SELECT = 8'hD4;
  localparam logic [7:0] CMD_BLOCK_XFER = 8'hD5;
  localparam logic [7:0] CMD_BANK_ACTIVATE = 8'hD8;
  // bank codes
  localparam logic [7:0] BANK_RUN = 8'h00;
  localparam logic [7:0] BANK_RAMP = 8'h01;
  localparam logic [7:0] BANK_LIGHT = 8'h02;
  localparam logic [7:0] BANK_RSV_FIRST = 8'h03;
  localparam logic [7:0] BANK_RSV_LAST = 8'hFD;
  localparam logic [7:0] BANK_ACTIVE = 8'hFE;
  localparam logic [7:0] BANK_INACTIVE = 8'hFF;
  localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
  // word indices inside a block
  localparam int COEF_ONE_IDX = 0;
  localparam int COEF_THREE_IDX = 2;
  localparam int GAIN_WORD_IDX = 4;
  localparam int LIMIT_WORD_IDX = 5;
  // gain word fields
  localparam int FE_GAIN_LSB = 30;
  localparam int NOMINAL_LSB = 24;
  localparam int POS_MID_LSB = 18;
  localparam int POS_LARGE_LSB = 12;
  localparam int NEG_MID_LSB = 6;
  localparam int NEG_LARGE_LSB = 0;
  // limit word fields
  localparam int BND_HIGHEST_LSB = 24;
  localparam int BND_HIGH_LSB = 16;
  localparam int BND_LOW_LSB = 8;
  localparam int BND_LOWEST_LSB = 0;
  localparam logic [5:0] GAIN_UNITY = 6'h04;
  localparam logic [31:0] GAIN_WORD_RESET = {2'h0, GAIN_UNITY, GAIN_UNITY, GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0] RES_COARSE_MV = 4'h8;
  localparam logic [4:0] LAST_BYTE = 5'h17;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_GET_BANK = 5'b00010,
    ST_GET_BLOCK = 5'b00100,
    ST_SEND_BLOCK = 5'b01000,
    ST_GET_ACT = 5'b10000
  } cglb_state_type;
endpackage

/* File: hw/cglb_segment_scaler.sv */
// segment selection and gain multiply for one error sample
// assumes words from the active hardware bank; purely combinational
`timescale 1ns/1ps
module cglb_segment_scaler #(
  parameter int ERR_W = cglb_pkg::ERR_WIDTH
) (
  input wire logic [31:0] gainWord,
  input wire logic [31:0] limitWord,
  input wire logic signed [ERR_W-1:0] errSample,
  output logic signed [ERR_W+cglb_pkg::MULT_W:0] scaled,
  output logic [2:0] segment
);
  import cglb_pkg::*;

  // full product width, so neither operand is padded silently
  localparam int PROD_W = ERR_W + MULT_W + 1;

  // boundaries are signed and need not sit symmetric about zero
  function automatic logic signed [ERR_W-1:0] bound(input logic [31:0] w, input int lsb);
    logic signed [LIMIT_W-1:0] raw;
    raw = $signed(w[lsb +: LIMIT_W]);
    return ERR_W'(raw);
  endfunction

  logic [MULT_W-1:0] mult;

  always_comb begin
    if (errSample > bound(limitWord, BND_HIGHEST_LSB)) begin
      segment = 3'h4;
      mult = gainWord[POS_LARGE_LSB +: MULT_W];
    end else if (errSample > bound(limitWord, BND_HIGH_LSB)) begin
      segment = 3'h3;
      mult = gainWord[POS_MID_LSB +: MULT_W];
    end else if (errSample >= bound(limitWord, BND_LOW_LSB)) begin
      segment = 3'h2;
      mult = gainWord[NOMINAL_LSB +: MULT_W];
    end else if (errSample >= bound(limitWord, BND_LOWEST_LSB)) begin
      segment = 3'h1;
      mult = gainWord[NEG_MID_LSB +: MULT_W];
    end else begin
      segment = 3'h0;
      mult = gainWord[NEG_LARGE_LSB +: MULT_W];
    end
  end

  // unsigned 4.2 multiply
  // result keeps the two fraction bits, so unity code 4 gives sample times four
  assign scaled = PROD_W'(errSample) * PROD_W'($signed({1'b0, mult}));
endmodule

/* File: test/cglb_host_model.sv */
// host side model of the management link, seen after byte decode
// assumes one caller at a time; requests launch on the falling edge
`timescale 1ns/1ps
module cglb_host_model (
  input wire logic sys_clk,
  output logic [1:0] pageSel,
  output logic cmdStart,
  output logic cmdRead,
  output logic [7:0] cmdCode,
  output logic wrValid,
  output logic [7:0] wrData,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic rdLast,
  input wire logic nackInvalid
);
  import cglb_pkg::*;
  int nackCount = 0;
  logic lastSeen = 1'b0;
  // quiet bus at time zero
  initial begin
    pageSel = 2'h0;
    cmdStart = 1'b0;
    cmdRead = 1'b0;
    cmdCode = 8'h00;
    wrValid = 1'b0;
    wrData = 8'h00;
  end
  // refusal pulses tallied so the bench compares counts, not timing
  always @(posedge sys_clk) begin
    if (nackInvalid === 1'b1) begin
      nackCount <= nackCount + 1;
    end
  end
  // one-cycle command start with page and direction
  task automatic cmd(input logic [7:0] code, input logic rd, input logic [1:0] pg);
    @(negedge sys_clk);
    cmdStart = 1'b1;
    cmdCode = code;
    cmdRead = rd;
    pageSel = pg;
  endtask
  // released lines toggle so a stale value can never pass for data
  task automatic idle();
    @(negedge sys_clk);
    cmdStart = 1'b0;
    wrValid = 1'b0;
    wrData = ~wrData;
    cmdCode = ~cmdCode;
  endtask
  task automatic put(input logic [7:0] b);
    @(negedge sys_clk);
    cmdStart = 1'b0;
    wrValid = 1'b1;
    wrData = b;
  endtask
  task automatic send_block(input logic [191:0] blk);
    for (int k = 0; k < 24; k++) begin
      put(blk[191-8*k -: 8]);
    end
  endtask
  // bounded wait for a reply; n stays 0 when none comes
  task automatic get_reply(output logic [191:0] q, output int n);
    int w;
    q = '0;
    n = 0;
    w = 0;
    lastSeen = 1'b0;
    while (rdValid !== 1'b1 && w < 6) begin
      idle();
      w++;
    end
    while (rdValid === 1'b1 && n < 24) begin
      q = {q[183:0], rdData};
      lastSeen = rdLast;
      n++;
      idle();
    end
  endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the gain bank manager
// assumes the host model drives the command side; errors driven here
`timescale 1ns/1ps
module tb;
  import cglb_pkg::*;
  typedef struct {logic [7:0] bank; logic wrNack; logic rdNack; logic useReset;} cglb_row_type;
  localparam logic [31:0] GAIN_C = {2'h3, 6'h04, 6'h08, 6'h0C, 6'h02, 6'h01};
  localparam logic [31:0] LIMIT_C = {2'h0, 6'h14, 2'h0, 6'h0A, 2'h0, 6'h36, 2'h0, 6'h2C};
  localparam logic [191:0] CUSTOM_BLK = {128'h11223344_55667788_99AABBCC_DDEEFF01, GAIN_C, LIMIT_C};
  localparam logic [191:0] RESET_BLK = {128'h0, GAIN_WORD_RESET, WORD_RESET};
  logic sys_clk, nrst, cmdStart, cmdRead, wrValid, rdValid, rdLast, nackInvalid;
  logic errValid, scaledValid;
  logic [1:0] pageSel, errRail, frontEndGain;
  logic [7:0] cmdCode, wrData, rdData;
  logic signed [8:0] errSample;
  logic signed [15:0] scaledErr;
  logic [2:0] errSegment;
  logic [3:0] resolutionMv, activeBankSel;
  int badCount = 0;
  int checks = 0;
  int mark = 0;
  cglb_row_type rows [7] = '{
    '{8'h00, 1'b0, 1'b0, 1'b0},
    '{8'h01, 1'b0, 1'b0, 1'b0},
    '{8'h02, 1'b0, 1'b0, 1'b0},
    '{8'hFF, 1'b0, 1'b0, 1'b0},
    '{8'h03, 1'b1, 1'b1, 1'b0},
    '{8'hFD, 1'b1, 1'b1, 1'b0},
    '{8'hFE, 1'b1, 1'b0, 1'b1}};

  cglb_bank_manager cglb_bank_manager_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pageSel(pageSel),
    .cmdStart(cmdStart),
    .cmdRead(cmdRead),
    .cmdCode(cmdCode),
    .wrValid(wrValid),
    .wrData(wrData),
    .rdValid(rdValid),
    .rdData(rdData),
    .rdLast(rdLast),
    .nackInvalid(nackInvalid),
    .errValid(errValid),
    .errRail(errRail),
    .errSample(errSample),
    .scaledValid(scaledValid),
    .scaledErr(scaledErr),
    .errSegment(errSegment),
    .frontEndGain(frontEndGain),
    .resolutionMv(resolutionMv),
    .activeBankSel(activeBankSel)
  );
  cglb_host_model cglb_host_model_inst (
    .sys_clk(sys_clk),
    .pageSel(pageSel),
    .cmdStart(cmdStart),
    .cmdRead(cmdRead),
    .cmdCode(cmdCode),
    .wrValid(wrValid),
    .wrData(wrData),
    .rdValid(rdValid),
    .rdData(rdData),
    .rdLast(rdLast),
    .nackInvalid(nackInvalid)
  );

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // refusals counted since the previous call, after the pulse has landed
  task automatic nk(input int expd);
    repeat (3) cglb_host_model_inst.idle();
    chk(cglb_host_model_inst.nackCount - mark, expd);
    mark = cglb_host_model_inst.nackCount;
  endtask
  // byte patterns differ per bank so aliasing between slots shows up
  function automatic logic [191:0] pat(input logic [7:0] bank);
    logic [191:0] v;
    for (int k = 0; k < 24; k++) begin
      v[191-8*k -: 8] = bank ^ 8'(k);
    end
    return v;
  endfunction
  task automatic sel(input logic [7:0] b, input logic [1:0] pg);
    cglb_host_model_inst.cmd(CMD_BANK_SELECT, 1'b0, pg);
    cglb_host_model_inst.put(b);
    cglb_host_model_inst.idle();
  endtask
  task automatic wr_blk(input logic [1:0] pg, input logic [191:0] blk);
    cglb_host_model_inst.cmd(CMD_BLOCK_XFER, 1'b0, pg);
    cglb_host_model_inst.send_block(blk);
    nk(0);
  endtask
  task automatic act(input logic [7:0] b, input logic [1:0] pg, input int expNack);
    cglb_host_model_inst.cmd(CMD_BANK_ACTIVATE, 1'b0, pg);
    cglb_host_model_inst.put(b);
    nk(expNack);
  endtask
  // a missing reply ends the run at once
  task automatic rd(input logic [7:0] code, input logic [1:0] pg, input logic [191:0] exp, input int expN);
    logic [191:0] q;
    int n;
    cglb_host_model_inst.cmd(code, 1'b1, pg);
    cglb_host_model_inst.get_reply(q, n);
    if (expN > 0 && n == 0) begin
      $display("timeout waiting for reply");
      badCount++;
      wrap_up();
    end
    chk(n, expN);
    chk(q, exp);
    chk(cglb_host_model_inst.lastSeen, expN > 0);
  endtask
  task automatic err_chk(input logic signed [8:0] s, input logic [2:0] sg, input logic signed [15:0] sc);
    @(negedge sys_clk);
    errValid = 1'b1;
    errRail = 2'h1;
    errSample = s;
    @(negedge sys_clk);
    errValid = 1'b0;
    errSample = ~s;
    chk(scaledValid, 1'b1);
    chk(errSegment, sg);
    chk(scaledErr, sc);
  endtask

  initial begin
    cglb_row_type r;
    nrst = 1'b0;
    errValid = 1'b0;
    errRail = 2'h0;
    errSample = 9'h000;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    chk(activeBankSel, 4'h0);
    chk({frontEndGain, resolutionMv}, {2'h0, RES_COARSE_MV});
    chk({rdValid, nackInvalid, scaledValid}, 3'h0);
    rd(CMD_BANK_SELECT, 2'h0, BANK_SELECT_RESET, 1);
    rd(CMD_BLOCK_XFER, 2'h0, RESET_BLK, 24);
    $display("test reset done");
    // first pass writes every writable bank and checks refusals, second reads back, so slots must not alias
    for (int i = 0; i < 14; i++) begin
      r = rows[i % 7];
      sel(r.bank, 2'h2);
      if (i < 7 && r.wrNack) begin
        cglb_host_model_inst.cmd(CMD_BLOCK_XFER, 1'b0, 2'h2);
        nk(1);
      end else if (i < 7) begin
        wr_blk(2'h2, pat(r.bank));
      end else begin
        rd(CMD_BLOCK_XFER, 2'h2, r.rdNack ? 192'h0 : (r.useReset ? RESET_BLK : pat(r.bank)),
          r.rdNack ? 0 : 24);
        nk(int'(r.rdNack));
      end
      $display("test row %0d done", i);
    end
    sel(BANK_RUN, 2'h1);
    wr_blk(2'h1, CUSTOM_BLK);
    sel(BANK_LIGHT, 2'h1);
    act(BANK_RUN, 2'h1, 0);
    chk(activeBankSel, 4'h2);
    rd(CMD_BANK_SELECT, 2'h1, BANK_LIGHT, 1);
    sel(BANK_ACTIVE, 2'h1);
    rd(CMD_BLOCK_XFER, 2'h1, CUSTOM_BLK, 24);
    err_chk(9'sd21, 3'h4, 16'sd252);
    err_chk(9'sd20, 3'h3, 16'sd160);
    err_chk(9'sd10, 3'h2, 16'sd40);
    err_chk(-9'sd10, 3'h2, -16'sd40);
    err_chk(-9'sd20, 3'h1, -16'sd40);
    err_chk(-9'sd21, 3'h0, -16'sd21);
    chk({frontEndGain, resolutionMv}, {2'h3, 4'h1});
    $display("test activate ram done");
    act(8'h05, 2'h1, 1);
    chk(activeBankSel, 4'h2);
    cglb_host_model_inst.cmd(CMD_BANK_ACTIVATE, 1'b1, 2'h1);
    nk(1);
    cglb_host_model_inst.cmd(8'h99, 1'b0, 2'h1);
    nk(1);
    $display("test refusals done");
    act(BANK_INACTIVE, 2'h1, 0);
    chk(activeBankSel, 4'h0);
    rd(CMD_BLOCK_XFER, 2'h1, RESET_BLK, 24);
    err_chk(9'sd10, 3'h4, 16'sd40);
    chk(resolutionMv, RES_COARSE_MV);
    act(BANK_INACTIVE, 2'h2, 0);
    chk(activeBankSel, 4'h4);
    rd(CMD_BLOCK_XFER, 2'h2, pat(BANK_INACTIVE), 24);
    $display("test swap done");
    @(negedge sys_clk);
    nrst = 1'b0;
    @(negedge sys_clk);
    chk(activeBankSel, 4'h0);
    nrst = 1'b1;
    rd(CMD_BANK_SELECT, 2'h0, BANK_SELECT_RESET, 1);
    $display("test second reset done");
    wrap_up();
  end
endmodule
